// >>> pwm_actuator.sv
// Load model on the pulse output: tallies high cycles and rising edges
// Assumes the pin is sampled on the unit's own clock
module pwm_actuator (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Driven pin
   input wire logic pulse_out,
   // Observations
   output int high_cycles,
   output int rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_r;
   ////////////////////////////////////////////////////////////
   // A purely passive load: it never drives back onto the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_cycles <= 0;
         rises <= 0;
         last_r <= 1'b0;
      end else begin
         last_r <= pulse_out;
         if (pulse_out === 1'b1) begin
            high_cycles <= high_cycles + 1;
         end
         if (pulse_out === 1'b1 && last_r !== 1'b1) begin
            rises <= rises + 1;
         end
      end
   end
endmodule : pwm_actuator

// >>> pwm_freq_consts.svh
// Offsets, field positions, reset values, job codes, fault codes and timing counts
// Assumes a 20 MHz APB clock; included by the package and the unit
`ifndef PWM_FREQ_CONSTS_SVH
`define PWM_FREQ_CONSTS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_CHANNEL     8'h04
`define OFS_JOB_REQ     8'h08
`define OFS_FJOB_CODE   8'h0c
`define OFS_FJOB_VAL    8'h10
`define OFS_OUT_VAL     8'h14
`define OFS_FJOB_STAT   8'h18
`define OFS_FJOB_RESULT 8'h1c
`define OFS_PJOB_CODE   8'h20
`define OFS_PJOB_VAL    8'h24
`define OFS_PJOB_STAT   8'h28
`define OFS_PJOB_RESULT 8'h2c
`define OFS_STATUS      8'h30

// Control bit positions
`define CTRL_FGATE  0
`define CTRL_PGATE  1
`define CTRL_ANALOG 2
`define CTRL_TB_1MS 3
// Job status word: fault code low, error and done above
`define JSTAT_ERR  16
`define JSTAT_DONE 17

// Frequency meter job codes and limits
`define JOB_NONE        16'h0000
`define FJOB_WR_INTEG   16'h0004
`define FJOB_RD_INTEG   16'h0084
`define INTEG_MIN       32'sd10
`define INTEG_MAX       32'sd10000
`define INTEG_RST       16'h0064
// Pulse job codes
`define PJOB_WR_PERIOD  16'h0001
`define PJOB_WR_DELAY   16'h0002
`define PJOB_WR_MINP    16'h0004
`define PJOB_RD_PERIOD  16'h0081
`define PJOB_RD_DELAY   16'h0082
`define PJOB_RD_MINP    16'h0084

// Fault codes
`define FLT_NONE        16'h0000
`define FLT_INTEG_LOW   16'h0221
`define FLT_INTEG_HIGH  16'h0222
`define FLT_FBAD_CODE   16'h02ff
`define FLT_PER_LOW     16'h0411
`define FLT_PER_HIGH    16'h0412
`define FLT_DLY_LOW     16'h0421
`define FLT_DLY_HIGH    16'h0422
`define FLT_MINP_LOW    16'h0431
`define FLT_MINP_HIGH   16'h0432
`define FLT_PBAD_CODE   16'h04ff
`define FLT_PARAM       16'h8001
`define FLT_CHANNEL     16'h8009
`define CHANNEL_LIMIT   16'h0003

// Pulse limits and reset values
`define PER_RST         16'h4e20
`define PER_MIN_1MS     32'sd1
`define PER_MIN_100US   32'sd4
`define UNIT_MAX        32'sd65535
`define MINP_RST        16'h0002
`define MINP_MIN_100US  32'sd2
`define PERMIL_FULL     16'h03e8
`define ANALOG_FULL     16'h6c00

// Time base
`define CLK_PERIOD_NS   50
`define TB_100US_NS     100000
`define TB_1MS_NS       1000000
`define TB_100US_CYC    (`TB_100US_NS / `CLK_PERIOD_NS)
`define TB_1MS_CYC      (`TB_1MS_NS / `CLK_PERIOD_NS)

`endif

// >>> pwm_freq_job_unit.sv
// Pulse output with on-delay and spike filter, plus job interfaces for the
// frequency meter and the pulse generator, all behind an APB slave.
// Assumes one 20 MHz clock; APB master keeps its request until pready.
// Behaviour
// R01: New job only on rising request edge
// R02: Meter codes: 00h none, 04h write, 84h read
// R03: Integration time write accepts 10 to 10000
// R04: Too low 0221h, too high 0222h, error set
// R05: Unknown code gives error and 02FFh
// R06: Requester waits for done before next job
// R07: Job handled at once, done low meanwhile
// R08: Fault code in status, 0000h if none
// R09: Channel above 3 faults with 8009h
// R10: Channel above device maximum faults 8001h
// R11: Read job value in result word, offset 28
// R12: Meter internal gate equals software gate
// R13: Gate follows the gate-enable level
// R14: Counting disabled while pulse mode active
// R15: Per-mil: pulse = value/1000 times period
// R16: Analog: pulse = value/27648 times period
// R17: Time base 1 ms or 0.1 ms, default 0.1
// R18: Output inactive for on-delay before pulses
// R19: Period 1..65535 or 0.4.., default 20000
// R20: Pulses or pauses below minimum suppressed
// R21: Pulse function raises no interrupts
// R22: Pulse gate open starts, close stops output
// R23: New timing applies from next period
// R24: Pulse codes 01/02/04 write, 81/82/84 read
// R25: Pulse range faults 0411h..0432h
// R26: Gate closed holds output low, restarts delay
`include "pwm_freq_consts.svh"
module pwm_freq_job_unit
   import pwm_freq_pkg::*;
#(
   parameter int MAX_CHANNEL = 1,
   parameter int TB_100US_CYCLES = `TB_100US_CYC,
   parameter int TB_1MS_CYCLES = `TB_1MS_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Actuator and status pins
   output logic pulse_out,
   output logic count_disable,
   output logic meter_gate
);
   import pwm_freq_pkg::*;

   state_s r;
   state_s n;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [15:0] chan_fault(input logic [15:0] ch);
      if (ch > `CHANNEL_LIMIT)
         return `FLT_CHANNEL; // R09
      else if (32'(ch) > MAX_CHANNEL)
         return `FLT_PARAM; // R10
      return `FLT_NONE;
   endfunction : chan_fault

   // Range check on a signed job value against two bounds
   function automatic logic [15:0] range_fault(input logic [31:0] v, input logic signed [31:0] lo,
                                               input logic signed [31:0] hi, input logic [15:0] f_lo,
                                               input logic [15:0] f_hi);
      if ($signed(v) < lo)
         return f_lo;
      else if ($signed(v) > hi)
         return f_hi;
      return `FLT_NONE;
   endfunction : range_fault

   // Pulse length from output value, with the spike filter applied
   function automatic logic [15:0] pulse_len(input logic [15:0] val, input logic analog,
                                             input logic [15:0] per, input logic [15:0] minp);
      logic [15:0] full;
      logic [15:0] v;
      logic [31:0] prod;
      logic [15:0] len;
      full = analog ? `ANALOG_FULL : `PERMIL_FULL;
      v = (val > full) ? full : val;
      prod = 32'(v) * 32'(per);
      len = analog ? 16'(prod / 32'(`ANALOG_FULL)) : 16'(prod / 32'(`PERMIL_FULL)); // R15 R16
      if (len < minp)
         len = 16'h0000; // R20
      else if ((per - len) < minp)
         len = per; // R20
      return len;
   endfunction : pulse_len

   function automatic logic [31:0] read_mux(input state_s s, input logic [7:0] a);
      case (a)
         `OFS_CTRL: return {28'h0000000, s.tb_1ms, s.analog, s.pgate, s.fgate};
         `OFS_CHANNEL: return {16'h0000, s.channel};
         `OFS_JOB_REQ: return {30'h00000000, s.req};
         `OFS_FJOB_CODE: return {16'h0000, s.fcode};
         `OFS_FJOB_VAL: return s.fval;
         `OFS_OUT_VAL: return {16'h0000, s.out_val};
         `OFS_FJOB_STAT: return {14'h0000, s.fj.done, s.fj.err, s.fj.stat};
         `OFS_FJOB_RESULT: return s.fj.res; // R11
         `OFS_PJOB_CODE: return {16'h0000, s.pcode};
         `OFS_PJOB_VAL: return s.pval;
         `OFS_PJOB_STAT: return {14'h0000, s.pj.done, s.pj.err, s.pj.stat};
         `OFS_PJOB_RESULT: return s.pj.res;
         `OFS_STATUS: return {28'h0000000, s.count_dis, s.pwm_out, s.pgate_sts, s.fgate_sts};
         default: return 32'h00000000;
      endcase
   endfunction : read_mux

   function automatic logic addr_ok(input logic [7:0] a);
      return (a <= `OFS_STATUS) && (a[1:0] == 2'b00);
   endfunction : addr_ok

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic acc;
   logic wr;
   logic [15:0] flt;
   logic [15:0] tick_lim;
   logic tick;
   logic signed [31:0] per_min;
   logic signed [31:0] minp_lo;

   always_comb begin
      n = r;
      flt = `FLT_NONE;
      // One wait state: read data are registered with pready; write data land as pready falls
      acc = psel & penable & ~r.pready;
      wr = psel & penable & r.pready & pwrite;
      n.pready = acc;
      n.pslverr = acc & ~addr_ok(paddr);
      n.prdata = acc ? read_mux(r, paddr) : 32'h00000000;
      if (wr) begin
         case (paddr)
            `OFS_CTRL: begin
               n.fgate = pwdata[`CTRL_FGATE]; // R13
               n.pgate = pwdata[`CTRL_PGATE]; // R13
               n.analog = pwdata[`CTRL_ANALOG];
               n.tb_1ms = pwdata[`CTRL_TB_1MS]; // R17
            end
            `OFS_CHANNEL: n.channel = pwdata[15:0];
            `OFS_JOB_REQ: n.req = pwdata[1:0];
            `OFS_FJOB_CODE: n.fcode = pwdata[15:0];
            `OFS_FJOB_VAL: n.fval = pwdata;
            `OFS_OUT_VAL: n.out_val = pwdata[15:0];
            `OFS_PJOB_CODE: n.pcode = pwdata[15:0];
            `OFS_PJOB_VAL: n.pval = pwdata;
            default: n.req = r.req;
         endcase
      end
      n.req_d = r.req;

      // Frequency meter job: one cycle busy, then the answer
      if (r.fj.busy) begin
         n.fj.busy = 1'b0;
         n.fj.done = 1'b1; // R07
         flt = chan_fault(r.channel);
         if (flt == `FLT_NONE) begin
            case (r.fcode) // R02
               `JOB_NONE: flt = `FLT_NONE;
               `FJOB_WR_INTEG: begin
                  flt = range_fault(r.fval, `INTEG_MIN, `INTEG_MAX, `FLT_INTEG_LOW, `FLT_INTEG_HIGH); // R03 R04
                  if (flt == `FLT_NONE)
                     n.integ = r.fval[15:0]; // R03
               end
               `FJOB_RD_INTEG: n.fj.res = {16'h0000, r.integ}; // R11
               default: flt = `FLT_FBAD_CODE; // R05
            endcase
         end
         n.fj.stat = flt; // R08
         n.fj.err = (flt != `FLT_NONE); // R04
      end else if (r.req[0] & ~r.req_d[0]) begin
         // Level alone never starts a job; a request during busy is dropped
         n.fj.busy = 1'b1; // R01 R06
         n.fj.done = 1'b0; // R07
      end

      // Pulse job
      per_min = r.tb_1ms ? `PER_MIN_1MS : `PER_MIN_100US;
      minp_lo = r.tb_1ms ? 32'sd0 : `MINP_MIN_100US;
      if (r.pj.busy) begin
         n.pj.busy = 1'b0;
         n.pj.done = 1'b1;
         flt = chan_fault(r.channel);
         if (flt == `FLT_NONE) begin
            case (r.pcode) // R24
               `JOB_NONE: flt = `FLT_NONE;
               `PJOB_WR_PERIOD: begin
                  flt = range_fault(r.pval, per_min, `UNIT_MAX, `FLT_PER_LOW, `FLT_PER_HIGH); // R19 R25
                  if (flt == `FLT_NONE)
                     n.period = r.pval[15:0];
               end
               `PJOB_WR_DELAY: begin
                  flt = range_fault(r.pval, 32'sd0, `UNIT_MAX, `FLT_DLY_LOW, `FLT_DLY_HIGH); // R18 R25
                  if (flt == `FLT_NONE)
                     n.delay = r.pval[15:0];
               end
               `PJOB_WR_MINP: begin
                  flt = range_fault(r.pval, minp_lo, 32'(r.period >> 1), `FLT_MINP_LOW,
                                    `FLT_MINP_HIGH); // R20 R25
                  if (flt == `FLT_NONE)
                     n.minp = r.pval[15:0];
               end
               `PJOB_RD_PERIOD: n.pj.res = {16'h0000, r.period};
               `PJOB_RD_DELAY: n.pj.res = {16'h0000, r.delay};
               `PJOB_RD_MINP: n.pj.res = {16'h0000, r.minp};
               default: flt = `FLT_PBAD_CODE;
            endcase
         end
         n.pj.stat = flt;
         n.pj.err = (flt != `FLT_NONE);
      end else if (r.req[1] & ~r.req_d[1]) begin
         n.pj.busy = 1'b1; // R01
         n.pj.done = 1'b0;
      end

      // Time base ticks; the prescaler rests while the output is stopped
      tick_lim = r.tb_1ms ? 16'(TB_1MS_CYCLES - 1) : 16'(TB_100US_CYCLES - 1); // R17
      tick = (r.tcnt >= tick_lim);
      n.tcnt = tick ? 16'h0000 : r.tcnt + 16'h0001;

      case (r.st)
         PW_IDLE: begin
            n.tcnt = 16'h0000;
            n.ucnt = 16'h0000;
            if (r.pgate) begin // R22
               if (r.delay == 16'h0000) begin
                  n.st = PW_RUN;
                  n.sh_period = r.period;
                  n.sh_pulse = pulse_len(r.out_val, r.analog, r.period, r.minp);
               end else begin
                  n.st = PW_DELAY; // R18
               end
            end
         end
         PW_DELAY: begin
            if (tick) begin
               if (r.ucnt >= r.delay - 16'h0001) begin // R18
                  n.st = PW_RUN;
                  n.ucnt = 16'h0000;
                  n.sh_period = r.period;
                  n.sh_pulse = pulse_len(r.out_val, r.analog, r.period, r.minp);
               end else begin
                  n.ucnt = r.ucnt + 16'h0001;
               end
            end
         end
         PW_RUN: begin
            if (tick) begin
               if (r.ucnt >= r.sh_period - 16'h0001) begin
                  // Within a run shadows reload only here, so a running period ends as begun
                  n.ucnt = 16'h0000;
                  n.sh_period = r.period; // R23
                  n.sh_pulse = pulse_len(r.out_val, r.analog, r.period, r.minp); // R23
               end else begin
                  n.ucnt = r.ucnt + 16'h0001;
               end
            end
         end
         default: n.st = PW_IDLE;
      endcase
      if (!r.pgate) begin
         n.st = PW_IDLE; // R26
      end

      n.pwm_out = (n.st == PW_RUN) && (n.ucnt < n.sh_pulse); // R26 R21
      n.count_dis = r.pgate; // R14
      n.fgate_sts = r.fgate; // R12
      n.pgate_sts = r.pgate;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.fj.done <= 1'b1; // R08
         r.pj.done <= 1'b1;
         r.integ <= `INTEG_RST;
         r.period <= `PER_RST; // R19
         r.minp <= `MINP_RST; // R20
         r.sh_period <= `PER_RST;
         r.st <= PW_IDLE;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign pulse_out = r.pwm_out;
   assign count_disable = r.count_dis;
   assign meter_gate = r.fgate_sts;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_job_cycle;
      !r.fj.done ##1 r.fj.done;
   endsequence

   property p_edge_job;
      (r.req[0] && !r.req_d[0] && !r.fj.busy) |=> s_job_cycle;
   endproperty
   a_edge_job: assert property (p_edge_job) else $error("job not run on request edge"); // R01

   property p_level_idle;
      (r.req[0] && r.req_d[0] && r.fj.done && !r.fj.busy) |=> r.fj.done;
   endproperty
   a_level_idle: assert property (p_level_idle) else $error("job started on steady level"); // R01

   property p_chan;
      (r.fj.busy && r.channel > 16'h0003) |=> (r.fj.stat == 16'h8009) && r.fj.err;
   endproperty
   a_chan: assert property (p_chan) else $error("channel fault code wrong"); // R09

   property p_integ_low;
      (r.fj.busy && r.channel == 16'h0000 && r.fcode == 16'h0004 && $signed(r.fval) < 10)
         |=> (r.fj.stat == 16'h0221) && r.fj.err;
   endproperty
   a_integ_low: assert property (p_integ_low) else $error("low integration fault wrong"); // R04

   property p_bad_code;
      (r.fj.busy && r.channel == 16'h0000 && r.fcode == 16'h0005) |=> (r.fj.stat == 16'h02ff);
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("invalid code fault wrong"); // R05

   property p_read;
      (r.fj.busy && r.channel == 16'h0000 && r.fcode == 16'h0084) |=> (r.fj.res == {16'h0000, $past(r.integ)});
   endproperty
   a_read: assert property (p_read) else $error("read result wrong"); // R11

   property p_err_stat;
      r.fj.err == (r.fj.stat != 16'h0000);
   endproperty
   a_err_stat: assert property (p_err_stat) else $error("error flag and code disagree"); // R08

   property p_gate;
      ##1 (meter_gate == $past(r.fgate));
   endproperty
   a_gate: assert property (p_gate) else $error("meter gate not following"); // R12

   property p_closed;
      // A reopen with zero on-delay may legally drive the second cycle high
      !r.pgate |=> !pulse_out ##1 (!pulse_out || $past(r.pgate));
   endproperty
   a_closed: assert property (p_closed) else $error("output active with gate closed"); // R26

   property p_count_off;
      r.pgate |=> count_disable;
   endproperty
   a_count_off: assert property (p_count_off) else $error("counting not disabled"); // R14

   property p_delay_low;
      (r.st == PW_DELAY) |-> !pulse_out;
   endproperty
   a_delay_low: assert property (p_delay_low) else $error("output active during on-delay"); // R18

   property p_start;
      $rose(r.pgate) |=> (r.st != PW_IDLE);
   endproperty
   a_start: assert property (p_start) else $error("output not started on gate open"); // R22

endmodule : pwm_freq_job_unit

// >>> pwm_freq_pkg.sv
// Types of the pulse and frequency-meter job unit
// Assumes the constants header sits in the include path
package pwm_freq_pkg;
   `include "pwm_freq_consts.svh"

   typedef enum logic [2:0] {
      PW_IDLE  = 3'b001,
      PW_DELAY = 3'b010,
      PW_RUN   = 3'b100
   } pwm_state_e;

   typedef struct packed {
      logic busy;
      logic done;
      logic err;
      logic [15:0] stat;
      logic [31:0] res;
   } job_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic fgate;
      logic pgate;
      logic analog;
      logic tb_1ms;
      logic [15:0] channel;
      logic [1:0] req;
      logic [1:0] req_d;
      logic [15:0] fcode;
      logic [31:0] fval;
      logic [15:0] pcode;
      logic [31:0] pval;
      logic [15:0] out_val;
      job_s fj;
      job_s pj;
      logic [15:0] integ;
      logic [15:0] period;
      logic [15:0] delay;
      logic [15:0] minp;
      logic [15:0] sh_period;
      logic [15:0] sh_pulse;
      pwm_state_e st;
      logic [15:0] ucnt;
      logic [15:0] tcnt;
      logic pwm_out;
      logic count_dis;
      logic fgate_sts;
      logic pgate_sts;
   } state_s;
endpackage : pwm_freq_pkg

// >>> tb_pwm_freq_job_unit.sv
// Self-checking bench: APB master, job model and pulse-width model
// Assumes the unit, its package and the actuator load are compiled first
`include "pwm_freq_consts.svh"
module tb_pwm_freq_job_unit
   import pwm_freq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TB_S = 4;
   localparam int TB_L = 10;
   localparam int MAXCH = 1;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic pulse_out, count_disable, meter_gate, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0] ctrl;
   int high_cycles, rises, num_errors, compares;
   int integ, period, delay, minp, chan, tk;
   int res [2];
   int mc [9] = '{'h84, 4, 4, 4, 'h84, 0, 5, 4, 'h84};
   int mv [9] = '{0, 9, 10001, 10, 0, 0, 0, -5, 0};
   int qc [12] = '{'h81, 1, 1, 1, 2, 2, 4, 4, 4, 'h82, 'h84, 7};
   int qv [12] = '{0, 3, 65536, 10, -1, 2, 1, 6, 2, 0, 0, 0};
   int chs [3] = '{4, 2, 1};
   pwm_freq_job_unit #(.MAX_CHANNEL(MAXCH), .TB_100US_CYCLES(TB_S), .TB_1MS_CYCLES(TB_L)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .pulse_out, .count_disable, .meter_gate);
   pwm_actuator load (.pclk, .presetn, .pulse_out, .high_cycles, .rises);
   ////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task test_done();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Request held until pready is sampled high; at most 16 cycles are waited
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   ////////////////////////////////////////////////////////////
   task job(input int f, input int c, input int v);
      int st, n;
      st = 0;
      if (chan > 3) st = 'h8009;
      else if (chan > MAXCH) st = 'h8001;
      else if (f == 0) begin
         case (c)
            0: st = 0;
            4: st = v < 10 ? 'h221 : v > 10000 ? 'h222 : 0;
            'h84: res[0] = integ;
            default: st = 'h2ff;
         endcase
         if (c == 4 && st == 0) integ = v;
      end else begin
         case (c)
            1: st = v < (ctrl[3] ? 1 : 4) ? 'h411 : v > 65535 ? 'h412 : 0;
            2: st = v < 0 ? 'h421 : v > 65535 ? 'h422 : 0;
            4: st = v < (ctrl[3] ? 0 : 2) ? 'h431 : v > period / 2 ? 'h432 : 0;
            'h81: res[1] = period;
            'h82: res[1] = delay;
            'h84: res[1] = minp;
            default: st = 'h4ff;
         endcase
         if (st == 0 && c == 1) period = v;
         if (st == 0 && c == 2) delay = v;
         if (st == 0 && c == 4) minp = v;
      end
      apb(1'b1, f ? `OFS_PJOB_CODE : `OFS_FJOB_CODE, c);
      apb(1'b1, f ? `OFS_PJOB_VAL : `OFS_FJOB_VAL, v);
      apb(1'b1, `OFS_JOB_REQ, 0);
      apb(1'b1, `OFS_JOB_REQ, f ? 2 : 1);
      n = 0;
      do begin
         apb(1'b0, f ? `OFS_PJOB_STAT : `OFS_FJOB_STAT, 0);
         n++;
      end while (rd[17] !== 1'b1 && n < 8);
      chk("job_status", {14'h0, 1'b1, st != 0, st[15:0]}, rd);
      apb(1'b0, f ? `OFS_PJOB_RESULT : `OFS_FJOB_RESULT, 0);
      chk("job_result", res[f], rd);
   endtask : job
   function int plen(input int v);
      int full, l;
      full = ctrl[2] ? 27648 : 1000;
      if (v > full) v = full;
      l = v * period / full;
      if (l < minp) l = 0;
      if (period - l < minp) l = period;
      return l;
   endfunction : plen
   // Any window of whole periods holds the same number of high cycles
   task meas(input int v);
      int h, e;
      tk = ctrl[3] ? TB_L : TB_S;
      apb(1'b1, `OFS_CTRL, {28'h0, ctrl});
      apb(1'b1, `OFS_OUT_VAL, v);
      repeat (2 * period * tk) @(posedge pclk);
      h = high_cycles;
      e = rises;
      repeat (2 * period * tk) @(posedge pclk);
      chk("high_cycles", 2 * plen(v) * tk * (ctrl[1] ? 1 : 0), high_cycles - h);
      chk("rises", (ctrl[1] && plen(v) > 0 && plen(v) < period) ? 2 : 0, rises - e);
   endtask : meas
   task open_gate();
      int n;
      tk = ctrl[3] ? TB_L : TB_S;
      ctrl[1] = 1'b1;
      apb(1'b1, `OFS_CTRL, {28'h0, ctrl});
      n = 0;
      while (pulse_out !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk("on_delay_fit", 1, n >= delay * tk - 2 && n <= delay * tk + 4);
      chk("count_disable", 1, count_disable);
   endtask : open_gate
   ////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      test_done();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ctrl} = '0;
      {num_errors, compares, chan} = '0;
      seed = 32'hda4f;
      integ = 100;
      period = 20000;
      delay = 0;
      minp = 2;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h34, 0);
      chk("unmapped_err", 1, er);
      chk("unmapped_data", 0, rd);
      apb(1'b1, 8'h3c, 32'h5);
      chk("unmapped_err", 1, er);
      apb(1'b0, `OFS_FJOB_STAT, 0);
      chk("meter_status", 32'h20000, rd);
      apb(1'b0, `OFS_PJOB_STAT, 0);
      chk("pulse_status", 32'h20000, rd);
      ctrl = 4'h1;
      apb(1'b1, `OFS_CTRL, {28'h0, ctrl});
      repeat (2) @(posedge pclk);
      chk("meter_gate", 1, meter_gate);
      ctrl = 4'h0;
      apb(1'b1, `OFS_CTRL, {28'h0, ctrl});
      repeat (2) @(posedge pclk);
      chk("meter_gate", 0, meter_gate);
      for (int i = 0; i < 9; i++) job(0, mc[i], mv[i] < 0 ? int'(rnd() % 9991) + 10 : mv[i]);
      for (int i = 0; i < 3; i++) begin
         chan = chs[i];
         apb(1'b1, `OFS_CHANNEL, chan);
         job(0, 'h84, 0);
         job(1, 'h81, 0);
      end
      // Steady request level must not start a second job
      job(0, 0, 0);
      apb(1'b1, `OFS_FJOB_CODE, 5);
      apb(1'b1, `OFS_JOB_REQ, 1);
      apb(1'b0, `OFS_FJOB_STAT, 0);
      chk("steady_req", 32'h20000, rd);
      for (int i = 0; i < 12; i++) job(1, qc[i], qv[i]);
      apb(1'b1, `OFS_OUT_VAL, 500);
      open_gate();
      for (int i = 0; i < 6; i++) begin
         ctrl[2] = rnd() % 2;
         ctrl[3] = i >= 4;
         meas(i == 0 ? 0 : i == 1 ? 30000 : int'(rnd() % (ctrl[2] ? 27649 : 1001)));
      end
      ctrl[2] = 1'b0;
      meas(500);
      ctrl[1] = 1'b0;
      meas(500);
      chk("count_disable", 0, count_disable);
      open_gate();
      test_done();
   end
endmodule : tb_pwm_freq_job_unit
